// >>> stlpc_pkg.sv
// Purpose: Shared constants for the serdes transmit level and power controller
// Assumes: APB register window of 4 KB, one 32-bit word per register
// Notes:   Lane registers sit in 16-byte slots from the lane base upward
package stlpc_pkg;
	// Global register byte offsets
	localparam logic [11:0] OFF_LINK_CTL2  = 12'h000;
	localparam logic [11:0] OFF_LINK_CTL   = 12'h004;
	localparam logic [11:0] OFF_LINK_STS2  = 12'h008;
	localparam logic [11:0] OFF_SERDES_CFG = 12'h00c;
	localparam logic [11:0] OFF_QUAD_CTL   = 12'h010;
	localparam logic [11:0] OFF_PORT_EN    = 12'h014;
	localparam logic [11:0] OFF_MARGIN_STS = 12'h018;
	localparam logic [11:0] OFF_LANE_BASE  = 12'h040;
	// Word slot inside a lane block
	localparam logic [1:0]  SLOT_TXA       = 2'h0;
	localparam logic [1:0]  SLOT_TXB       = 2'h1;
	localparam logic [1:0]  SLOT_RXEQ      = 2'h2;
	// Field positions
	localparam int          SDE_BIT        = 3;
	localparam int          CDE_BIT        = 4;
	localparam int          VALID_BIT      = 1;
	localparam int          QDEEP_BIT      = 1;
	localparam int          COMP_BIT       = 3;
	localparam int          USED_LSB       = 8;
	localparam int          BOOST_LSB      = 8;
	localparam int          LSG2_LSB       = 4;
	localparam int          FDC_LSB        = 8;
	localparam int          EQB_LSB        = 4;
	// Margin codes
	localparam logic [2:0]  MARGIN_NORMAL  = 3'h0;
	localparam logic [2:0]  MARGIN_MAX     = 3'h5;
	// Margin swing in mV, index 0 is the highest level
	localparam logic [4:0][9:0] MV_FULL = {10'h0c8, 10'h12c, 10'h1f4, 10'h2bc, 10'h384};
	localparam logic [4:0][9:0] MV_LOW  = {10'h064, 10'h0c8, 10'h12c, 10'h190, 10'h1f4};
	// Reset values
	localparam logic [4:0]  RST_LVL        = 5'h0f;
	localparam logic [1:0]  RST_BOOST      = 2'h1;
	localparam logic [3:0]  RST_LSG        = 4'h7;
	localparam logic [2:0]  RST_FDC        = 3'h0;
	localparam logic [3:0]  RST_EQ         = 4'h0;
	// Drive level source and lane power states
	typedef enum logic [1:0] {SRC_REG, SRC_LOWSWING, SRC_MARGIN} stlpc_src_type;
	typedef enum logic [1:0] {PS_P0, PS_P1, PS_P2, PS_DEEP} stlpc_pstate_type;
endpackage : stlpc_pkg

// >>> stlpc_ctrl.sv
// Purpose: Transmit swing source, low-swing, rx equalizer and lane power control
// Assumes: One quad of lanes, ltssm status inputs synchronous to pclk
// Notes:   Drive outputs are registered, one cycle behind the deciding state
`timescale 1ns/1ps

// Operation
// (RULE1) Non-normal margin field makes hardware set swing, lane level registers ignored.
// (RULE2) Margin levels 900..200 mV full swing, 500..100 mV low swing.
// (RULE3) In compliance, swing from margin, de-emphasis chosen by the ltssm.
// (RULE4) Entering compliance applies full or low swing margin values per mode.
// (RULE5) Per-lane amplitude boost stays in force during margining.
// (RULE6) New margin waits until ltssm passes a margin-update state.
// (RULE7) Software should retrain the link after changing the margin.
// (RULE8) Low-swing enable bit switches transmitter to roughly half swing.
// (RULE9) Merged ports need low-swing enable set in both serdes.
// (RULE10) Low swing forces de-emphasis off and marks de-emphasis status invalid.
// (RULE11) Low swing level comes from gen1 or gen2 field, codes rise monotonically.
// (RULE12) Each lane has rx equalizer zero and boost controls.
// (RULE13) Disabled wide port puts its quad in deep low power.
// (RULE14) Disabled narrow port lanes go deep; quad deep when all lanes disabled.
// (RULE15) Enabled port: quad on, only detected lanes active, rest powered down.
// (RULE16) Lanes dropped by width reduction sit in P1, idle, termination on.
// (RULE17) Each return to detect re-evaluates which lanes are used.
// (RULE18) Quad power-down bit powers down the whole quad.
// (RULE19) Low swing ignores fine and coarse de-emphasis controls.
// (RULE20) Applied margin held apart, loaded only on allowed training state.
module stlpc_ctrl #(
	parameter int LANES = 4
) (
	input  wire  logic                                   pclk,
	input  wire  logic                                   presetn,
	input  wire  logic                                   psel,
	input  wire  logic                                   penable,
	input  wire  logic                                   pwrite,
	input  wire  logic [11:0]                            paddr,
	input  wire  logic [31:0]                            pwdata,
	output logic       [31:0]                            prdata,
	output logic                                         pready,
	output logic                                         pslverr,
	input  wire  logic                                   ltssm_compliance,
	input  wire  logic                                   ltssm_margin_upd,
	input  wire  logic                                   ltssm_detect,
	input  wire  logic                                   ltssm_deemph_6db,
	input  wire  logic                                   link_up,
	input  wire  logic                                   gen2,
	input  wire  logic [LANES-1:0]                       lane_detected,
	input  wire  logic [LANES-1:0]                       lane_active,
	output logic                                         link_retrain,
	output stlpc_pkg::stlpc_src_type    [LANES-1:0]      lane_drive_src,
	output logic       [LANES-1:0][4:0]                  lane_drive_level,
	output logic       [LANES-1:0][1:0]                  lane_amp_boost,
	output logic       [9:0]                             tx_margin_mv,
	output logic                                         deemph_on,
	output logic                                         deemph_6db,
	output logic       [LANES-1:0][3:0]                  lane_rx_eq_zero,
	output logic       [LANES-1:0][3:0]                  lane_rx_eq_boost,
	output stlpc_pkg::stlpc_pstate_type [LANES-1:0]      lane_pstate,
	output logic       [LANES-1:0]                       lane_tx_elec_idle,
	output logic       [LANES-1:0]                       lane_rx_term_en,
	output logic                                         quad_deep_low,
	output logic                                         quad_power_down
);
	typedef struct packed {
		logic [2:0]                          tx_margin_field;
		logic                                selectable_deemph_field;
		logic                                compliance_or_current_deemph_field;
		logic                                low_swing_enable_bit;
		logic                                quad_power_down_bit;
		logic [LANES-1:0]                    port_en;
		logic [LANES-1:0][1:0]               tx_amplitude_boost;
		logic [LANES-1:0][4:0]               level;
		logic [LANES-1:0][3:0]               low_swing_level_gen1;
		logic [LANES-1:0][3:0]               low_swing_level_gen2;
		logic [LANES-1:0][2:0]               fine_deemph;
		logic [LANES-1:0][3:0]               rx_eq_zero_ctl;
		logic [LANES-1:0][3:0]               rx_eq_boost_ctl;
		logic [2:0]                          margin_app;
		logic                                comp_q;
		logic [LANES-1:0]                    used;
		logic                                retrain;
		logic [31:0]                         rdata;
		logic                                err;
		stlpc_pkg::stlpc_src_type [LANES-1:0] src;
		logic [LANES-1:0][4:0]               drv;
		logic [9:0]                          mv;
		logic                                deemph_on;
		logic                                deemph_6db;
		stlpc_pkg::stlpc_pstate_type [LANES-1:0] pst;
		logic                                qdeep;
	} stlpc_state_type;

	localparam stlpc_state_type RST = '{
		port_en:              {LANES{1'b1}},
		tx_amplitude_boost:   {LANES{stlpc_pkg::RST_BOOST}},
		level:                {LANES{stlpc_pkg::RST_LVL}},
		low_swing_level_gen1: {LANES{stlpc_pkg::RST_LSG}},
		low_swing_level_gen2: {LANES{stlpc_pkg::RST_LSG}},
		fine_deemph:          {LANES{stlpc_pkg::RST_FDC}},
		rx_eq_zero_ctl:       {LANES{stlpc_pkg::RST_EQ}},
		rx_eq_boost_ctl:      {LANES{stlpc_pkg::RST_EQ}},
		src:                  '{default: stlpc_pkg::SRC_REG},
		pst:                  '{default: stlpc_pkg::PS_DEEP},
		default:              '0
	};

	stlpc_state_type r;
	stlpc_state_type next_r;
	logic            margin_load;
	logic            margin_on;
	logic [1:0]      rl;
	logic [1:0]      wl;

	// True for an aligned word inside an implemented lane slot
	function automatic logic stlpc_lane_hit(input logic [11:0] a);
		return (a[11:6] == stlpc_pkg::OFF_LANE_BASE[11:6]) && (int'(a[5:4]) < LANES)
			&& (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
	endfunction : stlpc_lane_hit

	// Margin code to swing; reserved codes clamp to the lowest level
	function automatic logic [9:0] stlpc_margin_mv(input logic [2:0] code, input logic low);
		logic [2:0] idx;
		idx = (code == stlpc_pkg::MARGIN_NORMAL) ? 3'h0 :
			(code > stlpc_pkg::MARGIN_MAX) ? 3'h4 : code - 3'h1;
		return low ? stlpc_pkg::MV_LOW[idx] : stlpc_pkg::MV_FULL[idx];
	endfunction : stlpc_margin_mv

	assign rl = paddr[5:4];
	assign wl = paddr[5:4];

	// Next state: register file, margin holding, drive source and lane power
	always_comb
	begin
		next_r = r;
		next_r.retrain = 1'b0;
		// Read data is latched in the setup cycle so the access cycle needs no wait
		if (psel && !penable)
		begin
			next_r.rdata = '0;
			next_r.err = 1'b0;
			case (paddr)
				stlpc_pkg::OFF_LINK_CTL2:
				begin
					next_r.rdata[2:0] = r.tx_margin_field;
					next_r.rdata[stlpc_pkg::SDE_BIT] = r.selectable_deemph_field;
					next_r.rdata[stlpc_pkg::CDE_BIT] = r.compliance_or_current_deemph_field;
				end
				stlpc_pkg::OFF_LINK_CTL: next_r.rdata = '0;
				stlpc_pkg::OFF_LINK_STS2:
				begin
					next_r.rdata[0] = r.deemph_6db;
					// (RULE10) status invalid
					next_r.rdata[stlpc_pkg::VALID_BIT] = !r.low_swing_enable_bit;
				end
				stlpc_pkg::OFF_SERDES_CFG: next_r.rdata[0] = r.low_swing_enable_bit;
				stlpc_pkg::OFF_QUAD_CTL:
				begin
					next_r.rdata[0] = r.quad_power_down_bit;
					next_r.rdata[stlpc_pkg::QDEEP_BIT] = r.qdeep;
				end
				stlpc_pkg::OFF_PORT_EN:
				begin
					next_r.rdata[LANES-1:0] = r.port_en;
					next_r.rdata[stlpc_pkg::USED_LSB +: LANES] = r.used;
				end
				stlpc_pkg::OFF_MARGIN_STS:
				begin
					next_r.rdata[2:0] = r.margin_app;
					next_r.rdata[stlpc_pkg::COMP_BIT] = r.comp_q;
				end
				default:
				begin
					if (stlpc_lane_hit(paddr))
					begin
						case (paddr[3:2])
							stlpc_pkg::SLOT_TXA:
							begin
								next_r.rdata[4:0] = r.level[rl];
								next_r.rdata[stlpc_pkg::BOOST_LSB +: 2] = r.tx_amplitude_boost[rl];
							end
							stlpc_pkg::SLOT_TXB:
							begin
								next_r.rdata[3:0] = r.low_swing_level_gen1[rl];
								next_r.rdata[stlpc_pkg::LSG2_LSB +: 4] = r.low_swing_level_gen2[rl];
								next_r.rdata[stlpc_pkg::FDC_LSB +: 3] = r.fine_deemph[rl];
							end
							default:
							begin
								next_r.rdata[3:0] = r.rx_eq_zero_ctl[rl];
								next_r.rdata[stlpc_pkg::EQB_LSB +: 4] = r.rx_eq_boost_ctl[rl];
							end
						endcase
					end
					else
						next_r.err = 1'b1;
				end
			endcase
		end
		// Writes land at the access edge; unmapped and read-only words drop them
		if (psel && penable && pwrite && !r.err)
		begin
			case (paddr)
				stlpc_pkg::OFF_LINK_CTL2:
				begin
					next_r.tx_margin_field = pwdata[2:0];
					next_r.selectable_deemph_field = pwdata[stlpc_pkg::SDE_BIT];
					next_r.compliance_or_current_deemph_field = pwdata[stlpc_pkg::CDE_BIT];
				end
				stlpc_pkg::OFF_LINK_CTL: next_r.retrain = pwdata[0];
				stlpc_pkg::OFF_SERDES_CFG: next_r.low_swing_enable_bit = pwdata[0];
				stlpc_pkg::OFF_QUAD_CTL: next_r.quad_power_down_bit = pwdata[0];
				stlpc_pkg::OFF_PORT_EN: next_r.port_en = pwdata[LANES-1:0];
				default:
				begin
					if (stlpc_lane_hit(paddr))
					begin
						case (paddr[3:2])
							stlpc_pkg::SLOT_TXA:
							begin
								next_r.level[wl] = pwdata[4:0];
								next_r.tx_amplitude_boost[wl] = pwdata[stlpc_pkg::BOOST_LSB +: 2];
							end
							stlpc_pkg::SLOT_TXB:
							begin
								next_r.low_swing_level_gen1[wl] = pwdata[3:0];
								next_r.low_swing_level_gen2[wl] = pwdata[stlpc_pkg::LSG2_LSB +: 4];
								next_r.fine_deemph[wl] = pwdata[stlpc_pkg::FDC_LSB +: 3];
							end
							default:
							begin
								// (RULE12) rx equalizer pair
								next_r.rx_eq_zero_ctl[wl] = pwdata[3:0];
								next_r.rx_eq_boost_ctl[wl] = pwdata[stlpc_pkg::EQB_LSB +: 4];
							end
						endcase
					end
				end
			endcase
		end
		// (RULE6) (RULE20) deferred margin load
		// (RULE4) load on compliance entry
		next_r.comp_q = ltssm_compliance;
		margin_load = ltssm_margin_upd || (ltssm_compliance && !r.comp_q);
		if (margin_load)
			next_r.margin_app = r.tx_margin_field;
		// (RULE1) (RULE3) margin takes over
		margin_on = (next_r.margin_app != stlpc_pkg::MARGIN_NORMAL) || ltssm_compliance;
		// (RULE2) margin swing table
		next_r.mv = stlpc_margin_mv(next_r.margin_app, r.low_swing_enable_bit);
		// (RULE10) (RULE19) de-emphasis forced off
		next_r.deemph_on = !r.low_swing_enable_bit;
		next_r.deemph_6db = r.low_swing_enable_bit ? 1'b0 :
			(ltssm_compliance ? ltssm_deemph_6db : !r.selectable_deemph_field);
		// (RULE17) used lanes re-sampled in detect
		if (ltssm_detect)
			next_r.used = lane_detected;
		// (RULE13) (RULE14) quad deep when no lane enabled
		next_r.qdeep = ~|r.port_en;
		for (int i = 0; i < LANES; i++)
		begin
			// (RULE8) (RULE11) drive level source
			if (margin_on)
			begin
				next_r.src[i] = stlpc_pkg::SRC_MARGIN;
				next_r.drv[i] = {2'h0, next_r.margin_app};
			end
			else if (r.low_swing_enable_bit)
			begin
				next_r.src[i] = stlpc_pkg::SRC_LOWSWING;
				next_r.drv[i] = {1'b0, gen2 ? r.low_swing_level_gen2[i] : r.low_swing_level_gen1[i]};
			end
			else
			begin
				next_r.src[i] = stlpc_pkg::SRC_REG;
				next_r.drv[i] = r.level[i];
			end
			// (RULE18) explicit quad power-down
			// (RULE14) disabled lane deep
			// (RULE15) undetected lane off
			// (RULE16) width-reduced lane in P1
			if (r.quad_power_down_bit || next_r.qdeep || !r.port_en[i])
				next_r.pst[i] = stlpc_pkg::PS_DEEP;
			else if (!r.used[i])
				next_r.pst[i] = stlpc_pkg::PS_P2;
			else if (link_up && !lane_active[i])
				next_r.pst[i] = stlpc_pkg::PS_P1;
			else
				next_r.pst[i] = stlpc_pkg::PS_P0;
		end
	end

	// Single state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= RST;
		else
			r <= next_r;
	end

	// Zero-wait APB answer; error flag was set in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && r.err;
	assign prdata = r.rdata;
	assign link_retrain = r.retrain;
	assign lane_drive_src = r.src;
	assign lane_drive_level = r.drv;
	// (RULE5) boost kept under margin
	assign lane_amp_boost = r.tx_amplitude_boost;
	assign tx_margin_mv = r.mv;
	assign deemph_on = r.deemph_on;
	assign deemph_6db = r.deemph_6db;
	assign lane_rx_eq_zero = r.rx_eq_zero_ctl;
	assign lane_rx_eq_boost = r.rx_eq_boost_ctl;
	assign lane_pstate = r.pst;
	assign quad_deep_low = r.qdeep;
	assign quad_power_down = r.quad_power_down_bit;

	// Idle transmitter except in P0; termination stays on in P0 and P1
	always_comb
	begin
		for (int i = 0; i < LANES; i++)
		begin
			lane_tx_elec_idle[i] = (r.pst[i] != stlpc_pkg::PS_P0);
			lane_rx_term_en[i] = (r.pst[i] == stlpc_pkg::PS_P0) || (r.pst[i] == stlpc_pkg::PS_P1);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Checks on lane 0 stand for all lanes, they share one loop
	chk_margin_source: assert property ((next_r.margin_app != 3'h0) |=> // (RULE1)
		lane_drive_src[0] == stlpc_pkg::SRC_MARGIN) else $error("margin not driving swing");
	chk_margin_full_top: assert property ((next_r.margin_app == 3'h1 && !r.low_swing_enable_bit) // (RULE2)
		|=> tx_margin_mv == 10'h384) else $error("full swing top level wrong");
	chk_margin_low_bot: assert property ((next_r.margin_app == 3'h5 && r.low_swing_enable_bit) // (RULE2)
		|=> tx_margin_mv == 10'h064) else $error("low swing bottom level wrong");
	chk_compliance_deemph: assert property ((ltssm_compliance && !r.low_swing_enable_bit) // (RULE3)
		|=> deemph_6db == $past(ltssm_deemph_6db) && lane_drive_src[0] == stlpc_pkg::SRC_MARGIN)
		else $error("compliance de-emphasis or source wrong");
	chk_compliance_load: assert property ($rose(ltssm_compliance) |=> // (RULE4)
		r.margin_app == $past(r.tx_margin_field)) else $error("margin not applied at compliance");
	chk_margin_hold: assert property ((!ltssm_margin_upd && !$rose(ltssm_compliance)) // (RULE6)
		|=> $stable(r.margin_app)) else $error("margin changed outside allowed state");
	chk_margin_update: assert property (ltssm_margin_upd |=> // (RULE20)
		r.margin_app == $past(r.tx_margin_field)) else $error("margin not loaded");
	chk_boost_margin: assert property ((lane_drive_src[0] == stlpc_pkg::SRC_MARGIN // (RULE5)
		&& psel && penable && pwrite && !r.err && paddr == stlpc_pkg::OFF_LANE_BASE) |=>
		lane_amp_boost[0] == $past(pwdata[9:8])) else $error("boost lost in margin");
	chk_low_swing_off: assert property (r.low_swing_enable_bit |=> // (RULE10)
		!deemph_on && !deemph_6db) else $error("de-emphasis on in low swing");
	chk_low_swing_gen2: assert property ((r.low_swing_enable_bit && gen2 && !margin_on) // (RULE11)
		|=> lane_drive_level[0] == {1'b0, $past(r.low_swing_level_gen2[0])})
		else $error("gen2 low swing level wrong");
	chk_quad_deep: assert property ((r.port_en == '0) |=> quad_deep_low // (RULE13)
		&& lane_pstate[0] == stlpc_pkg::PS_DEEP) else $error("quad not deep");
	chk_unused_down: assert property ((r.port_en[0] && !r.used[0] && !r.quad_power_down_bit // (RULE15)
		&& !next_r.qdeep) |=> lane_pstate[0] == stlpc_pkg::PS_P2) else $error("unused lane on");
	chk_width_p1: assert property ((lane_pstate[0] == stlpc_pkg::PS_P1) |-> // (RULE16)
		lane_tx_elec_idle[0] && lane_rx_term_en[0]) else $error("P1 lane not idle");
	chk_detect_used: assert property (ltssm_detect |=> // (RULE17)
		r.used == $past(lane_detected)) else $error("used lanes not resampled");
	chk_quad_pd: assert property (r.quad_power_down_bit |=> // (RULE18)
		lane_pstate[0] == stlpc_pkg::PS_DEEP) else $error("quad power-down ignored");

	cov_compliance_low: cover property ($rose(ltssm_compliance) && r.low_swing_enable_bit);
	cov_margin_update: cover property (ltssm_margin_upd && r.tx_margin_field != r.margin_app);
	cov_width_reduce: cover property (lane_pstate[0] == stlpc_pkg::PS_P0 ##1
		lane_pstate[0] == stlpc_pkg::PS_P1);
	cov_bad_addr: cover property (pslverr);
endmodule : stlpc_ctrl

// >>> stlpc_link_model.sv
// Purpose: Behavioural link partner and training state model for the lane controller
// Assumes: Commands from the bench arrive as levels or one-cycle pulses on pclk
// Notes:   Detect lasts three cycles, then the link comes up with the width input as its active lanes
`timescale 1ns/1ps
module stlpc_link_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       link_retrain,
	input  wire logic       go_detect,
	input  wire logic       go_compliance,
	input  wire logic [3:0] present,
	input  wire logic [3:0] width,
	output logic            ltssm_detect,
	output logic            ltssm_margin_upd,
	output logic            ltssm_compliance,
	output logic            link_up,
	output logic [3:0]      lane_detected,
	output logic [3:0]      lane_active
);
	logic [2:0] det_cnt;
	logic [1:0] ret_cnt;

	// Training sequencer: a retrain passes through a margin-update state three cycles later
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			det_cnt          <= 3'h0;
			ret_cnt          <= 2'h0;
			link_up          <= 1'b0;
			ltssm_margin_upd <= 1'b0;
			ltssm_compliance <= 1'b0;
		end
		else
		begin
			ltssm_compliance <= go_compliance;
			det_cnt          <= go_detect ? 3'h3 : det_cnt - 3'(det_cnt != 3'h0);
			link_up          <= !go_detect && (det_cnt == 3'h1 || (link_up && det_cnt == 3'h0));
			ret_cnt          <= link_retrain ? 2'h2 : ret_cnt - 2'(ret_cnt != 2'h0);
			ltssm_margin_upd <= (ret_cnt == 2'h1);
		end
	end

	// Outside detect or with the link down the lane flags are inverted, never a kind value
	assign ltssm_detect  = (det_cnt != 3'h0);
	assign lane_detected = ltssm_detect ? present : ~present;
	assign lane_active   = link_up ? width : ~width;
endmodule : stlpc_link_model

// >>> tb.sv
// Purpose: Self-checking bench for the transmit level and lane power controller
// Assumes: Zero or more APB wait states, partner model on the training side
// Notes:   Expected values come from the documented levels, not from the design
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, ltssm_compliance, ltssm_margin_upd, ltssm_detect, link_up;
	logic ltssm_deemph_6db = 1'b0, gen2 = 1'b0, go_detect = 1'b0, go_compliance = 1'b0;
	logic [3:0] present = 4'h0, width = 4'h0, lane_detected, lane_active;
	logic link_retrain, deemph_on, deemph_6db, quad_deep_low, quad_power_down;
	stlpc_pkg::stlpc_src_type [3:0] lane_drive_src;
	stlpc_pkg::stlpc_pstate_type [3:0] lane_pstate;
	logic [3:0][4:0] lane_drive_level;
	logic [3:0][1:0] lane_amp_boost;
	logic [3:0][3:0] lane_rx_eq_zero, lane_rx_eq_boost;
	logic [3:0] lane_tx_elec_idle, lane_rx_term_en;
	logic [9:0] tx_margin_mv;
	logic [9:0] mv_tab [10] = '{10'h384, 10'h2bc, 10'h1f4, 10'h12c, 10'h0c8,
		10'h1f4, 10'h190, 10'h12c, 10'h0c8, 10'h064};
	int err_total = 0, n_checks = 0;

	stlpc_ctrl #(.LANES(4)) u_stlpc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ltssm_compliance(ltssm_compliance),
		.ltssm_margin_upd(ltssm_margin_upd), .ltssm_detect(ltssm_detect),
		.ltssm_deemph_6db(ltssm_deemph_6db), .link_up(link_up), .gen2(gen2),
		.lane_detected(lane_detected), .lane_active(lane_active), .link_retrain(link_retrain),
		.lane_drive_src(lane_drive_src), .lane_drive_level(lane_drive_level),
		.lane_amp_boost(lane_amp_boost), .tx_margin_mv(tx_margin_mv), .deemph_on(deemph_on),
		.deemph_6db(deemph_6db), .lane_rx_eq_zero(lane_rx_eq_zero),
		.lane_rx_eq_boost(lane_rx_eq_boost), .lane_pstate(lane_pstate),
		.lane_tx_elec_idle(lane_tx_elec_idle), .lane_rx_term_en(lane_rx_term_en),
		.quad_deep_low(quad_deep_low), .quad_power_down(quad_power_down));
	stlpc_link_model u_stlpc_link_model (.pclk(pclk), .presetn(presetn),
		.link_retrain(link_retrain), .go_detect(go_detect), .go_compliance(go_compliance),
		.present(present), .width(width), .ltssm_detect(ltssm_detect),
		.ltssm_margin_upd(ltssm_margin_upd), .ltssm_compliance(ltssm_compliance),
		.link_up(link_up), .lane_detected(lane_detected), .lane_active(lane_active));

	// Free-running 10 MHz clock
	always #50 pclk = ~pclk;

	task results;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task timeout;
		err_total++;
		$display("unexpected %0t wait ran out", $time);
		results();
	endtask : timeout

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask : chk

	// One APB transfer; the request stands until pready is seen high at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			timeout();
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		chk(32'(e), 32'h0, "write error flag");
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp, input logic ex, input string msg);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp, msg);
		chk(32'(e), 32'(ex), "read error flag");
	endtask : rd

	// Derived outputs trail a register change by at most two cycles
	task settle;
		repeat (3) @(posedge pclk);
		#10;
	endtask : settle

	task wait_upd;
		int n;
		n = 0;
		while (ltssm_margin_upd !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20)
			timeout();
		settle();
	endtask : wait_upd

	task detect(input logic [3:0] p, input logic [3:0] w);
		int n;
		@(posedge pclk);
		present   <= p;
		width     <= w;
		go_detect <= 1'b1;
		@(posedge pclk);
		go_detect <= 1'b0;
		n = 0;
		while (link_up !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20)
			timeout();
		settle();
	endtask : detect

	// Main sequence: registers, lane power, margining, low swing, compliance
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk(32'(lane_pstate), 32'h0aa, "unused lanes after reset");
		rd(12'h040, 32'h10f, 1'b0, "lane level reset");
		rd(12'h044, 32'h077, 1'b0, "low swing reset");
		rd(12'h020, 32'h0, 1'b1, "unmapped read");
		rd(12'h04c, 32'h0, 1'b1, "lane slot three");
		wr(12'h058, 32'h05a);
		settle();
		chk(32'({lane_rx_eq_boost[1], lane_rx_eq_zero[1]}), 32'h05a, "rx equalizer");
		detect(4'h7, 4'h7);
		chk(32'(lane_pstate), 32'h080, "detected lanes active");
		rd(12'h014, 32'h70f, 1'b0, "used lanes");
		@(posedge pclk);
		width <= 4'h1;
		settle();
		chk(32'(lane_pstate), 32'h094, "width reduced to P1");
		chk(32'({lane_tx_elec_idle, lane_rx_term_en}), 32'h0e7, "idle and termination");
		detect(4'hf, 4'hf);
		chk(32'(lane_pstate), 32'h000, "redetect uses all lanes");
		wr(12'h014, 32'h007);
		settle();
		chk(32'({quad_deep_low, lane_pstate}), 32'h0c0, "narrow port deep");
		wr(12'h014, 32'h000);
		settle();
		chk(32'({quad_deep_low, lane_pstate}), 32'h1ff, "whole quad deep");
		rd(12'h010, 32'h002, 1'b0, "quad deep status");
		wr(12'h014, 32'h00f);
		wr(12'h010, 32'h001);
		settle();
		chk(32'({quad_power_down, lane_pstate}), 32'h1ff, "quad power down");
		wr(12'h010, 32'h000);
		wr(12'h000, 32'h003);
		settle();
		chk(32'(lane_drive_src[0]), 32'(stlpc_pkg::SRC_REG), "margin held back");
		rd(12'h018, 32'h0, 1'b0, "applied margin held");
		wr(12'h004, 32'h001);
		wait_upd();
		chk(32'(lane_drive_src[0]), 32'(stlpc_pkg::SRC_MARGIN), "margin source");
		chk(32'({lane_amp_boost[0], lane_drive_level[0]}), 32'h023, "boost kept");
		rd(12'h018, 32'h003, 1'b0, "applied margin");
		wr(12'h040, 32'h21a);
		settle();
		chk(32'(lane_drive_level[0]), 32'h003, "lane level ignored");
		chk(32'(lane_amp_boost[0]), 32'h002, "boost written in margin");
		for (int m = 0; m < 10; m++)
		begin
			wr(12'h00c, 32'(m / 5));
			wr(12'h000, 32'((m % 5) + 1));
			wr(12'h004, 32'h001);
			wait_upd();
			chk(32'(tx_margin_mv), 32'(mv_tab[m]), "margin swing");
		end
		wr(12'h000, 32'h008);
		wr(12'h044, 32'h792);
		wr(12'h004, 32'h001);
		wait_upd();
		chk(32'(lane_drive_src[0]), 32'(stlpc_pkg::SRC_LOWSWING), "low swing source");
		chk(32'({deemph_on, lane_drive_level[0]}), 32'h002, "gen1 level, no deemph");
		rd(12'h008, 32'h0, 1'b0, "deemph status invalid");
		@(posedge pclk);
		gen2 <= 1'b1;
		settle();
		chk(32'(lane_drive_level[0]), 32'h009, "gen2 low swing level");
		// Selectable -3.5 dB so the compliance choice below differs from the register choice
		wr(12'h000, 32'h00a);
		go_compliance <= 1'b1;
		settle();
		chk(32'({deemph_on, tx_margin_mv}), 32'h190, "low swing compliance");
		@(posedge pclk);
		go_compliance <= 1'b0;
		ltssm_deemph_6db <= 1'b1;
		wr(12'h00c, 32'h000);
		settle();
		@(posedge pclk);
		go_compliance <= 1'b1;
		settle();
		chk(32'({deemph_6db, tx_margin_mv}), 32'h6bc, "full swing compliance");
		chk(32'(lane_drive_src[2]), 32'(stlpc_pkg::SRC_MARGIN), "compliance source");
		results();
	end
endmodule : tb
